// ### hdl/ftac_pkg.sv
// Constants shared by the flash table access controller.
// Assumes a 125 MHz processor clock and a byte-wide register port.
package ftac_pkg;

  // Register port indices
  localparam logic [2:0] FTAC_IDX_NVM_CONTROL = 3'h0;
  localparam logic [2:0] FTAC_IDX_UNLOCK_PORT = 3'h1;
  localparam logic [2:0] FTAC_IDX_BYTE_LATCH = 3'h2;
  localparam logic [2:0] FTAC_IDX_PTR_LOW = 3'h3;
  localparam logic [2:0] FTAC_IDX_PTR_HIGH = 3'h4;
  localparam logic [2:0] FTAC_IDX_PTR_UPPER = 3'h5;

  // Field positions in nvm_control
  localparam int FTAC_BIT_SPACE_SEL = 7;
  localparam int FTAC_BIT_CFG_SPACE = 6;
  localparam int FTAC_BIT_ERASE_SEL = 4;
  localparam int FTAC_BIT_ABORT = 3;
  localparam int FTAC_BIT_PROG_EN = 2;
  localparam int FTAC_BIT_START = 1;

  // Reset values
  localparam logic [7:0] FTAC_RST_NVM_CONTROL = 8'h00;
  localparam logic [7:0] FTAC_RST_BYTE = 8'h00;
  localparam logic [21:0] FTAC_RST_POINTER = 22'h000000;
  localparam logic [7:0] FTAC_HOLD_ERASED = 8'hff;

  // Unlock keys
  localparam logic [7:0] FTAC_KEY_FIRST = 8'h55;
  localparam logic [7:0] FTAC_KEY_SECOND = 8'haa;

  // Geometry
  localparam int FTAC_PTR_W = 22;
  localparam int FTAC_AUTO_W = 21;
  localparam int FTAC_HOLD_DEPTH = 64;
  localparam int FTAC_HOLD_IDX_W = 6;

  // Timing: erase/program cycle about 2 ms
  localparam int FTAC_CLK_PERIOD_NS = 8;
  localparam int FTAC_PROG_TIME_NS = 2000000;
  localparam int FTAC_PROG_CYCLES = FTAC_PROG_TIME_NS / FTAC_CLK_PERIOD_NS;

  // Pointer actions of a table instruction
  typedef enum logic [1:0] {
    FTAC_PTR_KEEP,
    FTAC_PTR_POST_INC,
    FTAC_PTR_POST_DEC,
    FTAC_PTR_PRE_INC
  } ftac_ptr_mode_e;

  // Target memory space
  typedef enum logic [1:0] {
    FTAC_SPACE_EEPROM,
    FTAC_SPACE_PROGRAM,
    FTAC_SPACE_CONFIG
  } ftac_space_e;

endpackage

// ### hdl/ftac_hold_block.sv
// Holding register block collecting one write block of flash data.
// Assumes index, data and strobes come from logic on the same clock.
`timescale 1ns/100ps
module ftac_hold_block #(
  parameter int DEPTH = 64,
  parameter int IDX_W = 6
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Byte write and bulk refill
  input wire logic wr_en_in,
  input wire logic [IDX_W-1:0] wr_idx_in,
  input wire logic [7:0] wr_data_in,
  input wire logic refill_in,
  // Whole block towards the array
  output logic [DEPTH*8-1:0] block_data_out
);
  import ftac_pkg::*;

  // One byte register per entry; refill wins over a byte write
  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
        block_data_out[i*8 +: 8] <= FTAC_HOLD_ERASED;
      end else if (refill_in) begin
        block_data_out[i*8 +: 8] <= FTAC_HOLD_ERASED;
      end else if (wr_en_in && wr_idx_in == IDX_W'(i)) begin
        block_data_out[i*8 +: 8] <= wr_data_in;
      end
    end
  end

endmodule

// ### hdl/ftac_ctrl.sv
// Flash table access controller: byte latch, pointer, unlock, cycle timer.
// Assumes the core drives register and table strobes on clock_in, and
// that the flash array answers a read with its word in the same cycle.
//
// Operation
// - Config space bit overrides space select; software clears it first.
// - Erase select set makes start erase the block, else program it.
// - Start requests are ignored unless program enable is set.
// - Setting start after unlock and enables begins the cycle.
// - Hardware clears start at completion; firmware cannot clear it.
// - Master-clear or watchdog reset during a cycle sets abort flag.
// - Byte latch is an 8-bit register holding each moved byte.
// - Pointer joins upper, high and low registers into 22 bits.
// - Low 21 bits address program space; top bit selects config space.
// - Automatic pointer updates change only the low 21 bits.
// - Table ops keep, post-increment, post-decrement or pre-increment.
// - Table read loads one byte chosen by all 22 pointer bits.
// - Words are 16 bits; pointer bit 0 picks high or low byte.
// - Table write stores latch into holding register of six low bits.
// - Pointer bits above six never affect which holding register is hit.
// - Program copies whole holding block to block of upper bits.
// - Erase clears 64-byte block from bits 21..6, ignoring 5..0.
// - Smallest erase is one block; no word or bulk erase here.
// - Writes 55h then AAh to unlock port, then start, or refuse.
// - The core is stalled while an erase or program cycle runs.
// - The stall lasts about 2 ms, set by the internal timer.
// - Holding registers reset to FFh on reset_n_in and after each completed program cycle.
`timescale 1ns/100ps
module ftac_ctrl #(
  parameter int PROG_CYCLES = ftac_pkg::FTAC_PROG_CYCLES,
  parameter int HOLD_DEPTH = ftac_pkg::FTAC_HOLD_DEPTH
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_n_in,
  // Reset events from the reset controller (single-cycle pulses)
  input wire logic mclr_event_in,
  input wire logic wdt_event_in,
  // Special function register port
  input wire logic [2:0] sfr_idx_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  // Table instruction request from the core
  input wire logic tbl_req_in,
  input wire logic tbl_is_write_in,
  input wire ftac_pkg::ftac_ptr_mode_e tbl_mode_in,
  output logic tbl_done_out,
  output logic cpu_stall_out,
  // Flash array read port
  output logic flash_rd_out,
  output logic [21:0] flash_rd_addr_out,
  output ftac_pkg::ftac_space_e flash_space_out,
  input wire logic [15:0] flash_word_in,
  // Flash array erase and program port
  output logic flash_erase_out,
  output logic flash_program_out,
  output logic [15:0] flash_block_out,
  output ftac_pkg::ftac_space_e flash_op_space_out,
  output logic [HOLD_DEPTH*8-1:0] flash_data_out
);
  import ftac_pkg::*;

  localparam int CNT_W = $clog2(PROG_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PROG_CYCLES - 1);

  typedef enum logic [1:0] {
    FTAC_UL_IDLE,
    FTAC_UL_GOT_FIRST,
    FTAC_UL_ARMED
  } ftac_unlock_e;

  logic space_sel_q;
  logic cfg_space_q;
  logic erase_sel_q;
  logic abort_q;
  logic prog_en_q;
  logic start_q;
  logic [7:0] latch_q;
  logic [21:0] ptr_q;
  logic [21:0] ptr_d;
  logic [21:0] access_addr;
  logic [20:0] ptr_inc;
  logic [20:0] ptr_dec;
  ftac_unlock_e unlock_q;
  ftac_unlock_e unlock_d;
  logic [CNT_W-1:0] cnt_q;
  logic rd_pend_q;
  logic rd_byte_sel_q;
  logic wr_done_q;
  logic start_req;
  logic start_go;
  logic cycle_end;
  logic reset_event;
  logic hold_wr;
  logic ctl_wr;
  ftac_space_e space_now;

  // Bus strobes; table ops ignored while a cycle stalls the core
  assign ctl_wr = sfr_wr_in && sfr_idx_in == FTAC_IDX_NVM_CONTROL;
  assign reset_event = mclr_event_in || wdt_event_in;
  assign start_req = ctl_wr && sfr_wdata_in[FTAC_BIT_START] && !start_q;
  assign start_go = start_req && prog_en_q
    && unlock_q == FTAC_UL_ARMED;
  assign cycle_end = start_q && cnt_q == CNT_LAST;
  assign cpu_stall_out = start_q;
  assign hold_wr = tbl_req_in && tbl_is_write_in && !start_q;

  // Config space overrides the space select
  always_comb begin
    if (cfg_space_q) begin
      space_now = FTAC_SPACE_CONFIG;
    end else if (space_sel_q) begin
      space_now = FTAC_SPACE_PROGRAM;
    end else begin
      space_now = FTAC_SPACE_EEPROM;
    end
  end

  // Auto-update arithmetic on the low 21 bits only
  assign ptr_inc = ptr_q[20:0] + 21'h000001;
  assign ptr_dec = ptr_q[20:0] - 21'h000001;

  // Access address: pre-increment uses the bumped pointer
  always_comb begin
    if (tbl_mode_in == FTAC_PTR_PRE_INC) begin
      access_addr = {ptr_q[21], ptr_inc};
    end else begin
      access_addr = ptr_q;
    end
  end

  // Next pointer: table op wins; register writes only without one
  always_comb begin
    ptr_d = ptr_q;
    if (tbl_req_in && !start_q) begin
      case (tbl_mode_in)
        FTAC_PTR_KEEP: ptr_d = ptr_q;
        FTAC_PTR_POST_INC: ptr_d = {ptr_q[21], ptr_inc};
        FTAC_PTR_POST_DEC: ptr_d = {ptr_q[21], ptr_dec};
        FTAC_PTR_PRE_INC: ptr_d = {ptr_q[21], ptr_inc};
        default: ptr_d = ptr_q;
      endcase
    end else if (sfr_wr_in) begin
      case (sfr_idx_in)
        FTAC_IDX_PTR_LOW: ptr_d[7:0] = sfr_wdata_in;
        FTAC_IDX_PTR_HIGH: ptr_d[15:8] = sfr_wdata_in;
        FTAC_IDX_PTR_UPPER: ptr_d[21:16] = sfr_wdata_in[5:0];
        default: ptr_d = ptr_q;
      endcase
    end
  end

  // Byte pointer register
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ptr_q <= FTAC_RST_POINTER;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  // Unlock sequencer: port keeps no data, any stray access drops it
  always_comb begin
    unlock_d = unlock_q;
    if (sfr_wr_in || sfr_rd_in) begin
      case (unlock_q)
        FTAC_UL_IDLE: begin
          if (sfr_wr_in && sfr_idx_in == FTAC_IDX_UNLOCK_PORT
              && sfr_wdata_in == FTAC_KEY_FIRST) begin
            unlock_d = FTAC_UL_GOT_FIRST;
          end
        end
        FTAC_UL_GOT_FIRST: begin
          if (sfr_wr_in && sfr_idx_in == FTAC_IDX_UNLOCK_PORT
              && sfr_wdata_in == FTAC_KEY_SECOND) begin
            unlock_d = FTAC_UL_ARMED;
          end else begin
            unlock_d = FTAC_UL_IDLE;
          end
        end
        FTAC_UL_ARMED: unlock_d = FTAC_UL_IDLE;
        default: unlock_d = FTAC_UL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      unlock_q <= FTAC_UL_IDLE;
    end else if (reset_event) begin
      unlock_q <= FTAC_UL_IDLE;
    end else begin
      unlock_q <= unlock_d;
    end
  end

  // Control bits; soft resets return erase select and program enable to defaults
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      space_sel_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_SPACE_SEL];
      cfg_space_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_CFG_SPACE];
      erase_sel_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_ERASE_SEL];
      prog_en_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_PROG_EN];
    end else if (reset_event) begin
      // Space bits kept so an abort can be traced afterwards
      erase_sel_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_ERASE_SEL];
      prog_en_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_PROG_EN];
    end else if (ctl_wr && !start_q) begin
      space_sel_q <= sfr_wdata_in[FTAC_BIT_SPACE_SEL];
      cfg_space_q <= sfr_wdata_in[FTAC_BIT_CFG_SPACE];
      erase_sel_q <= sfr_wdata_in[FTAC_BIT_ERASE_SEL];
      prog_en_q <= sfr_wdata_in[FTAC_BIT_PROG_EN];
    end
  end

  // Start bit: only set by a legal start, only cleared by hardware
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      start_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_START];
    end else if (reset_event || cycle_end) begin
      start_q <= 1'b0;
    end else if (start_go) begin
      start_q <= 1'b1;
    end
  end

  // Abort flag: raised at start, dropped only on clean completion
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      abort_q <= FTAC_RST_NVM_CONTROL[FTAC_BIT_ABORT];
    end else if (start_go) begin
      abort_q <= 1'b1;
    end else if (reset_event && start_q) begin
      abort_q <= 1'b1;
    end else if (cycle_end) begin
      abort_q <= 1'b0;
    end
  end

  // Programming timer sets the stall length
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q <= '0;
    end else if (!start_q || cycle_end || reset_event) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CNT_W'(1);
    end
  end

  // Array command; block address ignores the six low bits
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_erase_out <= 1'b0;
      flash_program_out <= 1'b0;
      flash_block_out <= 16'h0000;
      flash_op_space_out <= FTAC_SPACE_EEPROM;
    end else if (start_go && !reset_event) begin
      flash_erase_out <= erase_sel_q;
      flash_program_out <= !erase_sel_q;
      flash_block_out <= ptr_q[21:6];
      flash_op_space_out <= space_now;
    end else if (cycle_end || reset_event) begin
      // One block per cycle; no larger erase exists here
      flash_erase_out <= 1'b0;
      flash_program_out <= 1'b0;
    end
  end

  // Table read: word fetched, byte picked one cycle later
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_rd_out <= 1'b0;
      flash_rd_addr_out <= FTAC_RST_POINTER;
      flash_space_out <= FTAC_SPACE_EEPROM;
      rd_pend_q <= 1'b0;
      rd_byte_sel_q <= 1'b0;
    end else begin
      flash_rd_out <= tbl_req_in && !tbl_is_write_in && !start_q;
      rd_pend_q <= tbl_req_in && !tbl_is_write_in && !start_q;
      if (tbl_req_in && !tbl_is_write_in && !start_q) begin
        flash_rd_addr_out <= access_addr;
        rd_byte_sel_q <= access_addr[0];
        flash_space_out <= access_addr[21] ? FTAC_SPACE_CONFIG
          : FTAC_SPACE_PROGRAM;
      end
    end
  end

  // Byte latch: table read result or register write
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      latch_q <= FTAC_RST_BYTE;
    end else if (rd_pend_q) begin
      latch_q <= rd_byte_sel_q ? flash_word_in[15:8]
        : flash_word_in[7:0];
    end else if (sfr_wr_in && sfr_idx_in == FTAC_IDX_BYTE_LATCH) begin
      latch_q <= sfr_wdata_in;
    end
  end

  // Completion strobe for table writes, matches read latency
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_done_q <= 1'b0;
    end else begin
      wr_done_q <= hold_wr;
    end
  end
  assign tbl_done_out = wr_done_q || rd_pend_q;

  // Holding block; index uses only six low bits of the address
  ftac_hold_block #(
    .DEPTH(HOLD_DEPTH),
    .IDX_W(FTAC_HOLD_IDX_W)
  ) u_hold (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .wr_en_in(hold_wr),
    .wr_idx_in(access_addr[FTAC_HOLD_IDX_W-1:0]),
    .wr_data_in(latch_q),
    .refill_in(cycle_end && flash_program_out),
    .block_data_out(flash_data_out)
  );

  // Register read mux; unlock port has no storage
  always_comb begin
    sfr_rdata_out = 8'h00;
    case (sfr_idx_in)
      FTAC_IDX_NVM_CONTROL: begin
        sfr_rdata_out[FTAC_BIT_SPACE_SEL] = space_sel_q;
        sfr_rdata_out[FTAC_BIT_CFG_SPACE] = cfg_space_q;
        sfr_rdata_out[FTAC_BIT_ERASE_SEL] = erase_sel_q;
        sfr_rdata_out[FTAC_BIT_ABORT] = abort_q;
        sfr_rdata_out[FTAC_BIT_PROG_EN] = prog_en_q;
        sfr_rdata_out[FTAC_BIT_START] = start_q;
      end
      FTAC_IDX_UNLOCK_PORT: sfr_rdata_out = 8'h00;
      FTAC_IDX_BYTE_LATCH: sfr_rdata_out = latch_q;
      FTAC_IDX_PTR_LOW: sfr_rdata_out = ptr_q[7:0];
      FTAC_IDX_PTR_HIGH: sfr_rdata_out = ptr_q[15:8];
      FTAC_IDX_PTR_UPPER: sfr_rdata_out = {2'b00, ptr_q[21:16]};
      default: sfr_rdata_out = 8'h00;
    endcase
  end

endmodule

// ### tb/ftac_flash_model.sv
// Flash array stand-in answering byte-address reads with a known word.
// Assumes the controller samples the word while its read strobe is high.
`timescale 1ns/100ps
module ftac_flash_model (
  // Read request
  input wire logic rd_in,
  input wire logic [21:0] addr_in,
  // Word back
  output logic [15:0] word_out
);
  // Word from the word address; inverted outside reads so nothing leaks
  always_comb begin
    if (rd_in) begin
      word_out = {addr_in[8:1] ^ 8'ha5, addr_in[8:1]};
    end else begin
      word_out = ~{addr_in[8:1] ^ 8'ha5, addr_in[8:1]};
    end
  end
endmodule

// ### tb/ftac_ctrl_sva.sv
// Port checker for the flash table access controller.
// Assumes one clock domain; bound onto every controller instance.
`timescale 1ns/100ps
module ftac_ctrl_sva #(
  parameter int PROG_CYCLES = 20,
  parameter int HOLD_DEPTH = 64
) (
  // Clock, reset and reset events
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic mclr_event_in,
  input wire logic wdt_event_in,
  // Register port
  input wire logic [2:0] sfr_idx_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic [7:0] sfr_rdata_out,
  // Table requests
  input wire logic tbl_req_in,
  input wire logic tbl_is_write_in,
  input wire logic tbl_done_out,
  input wire logic cpu_stall_out,
  // Flash array
  input wire logic flash_rd_out,
  input wire logic [21:0] flash_rd_addr_out,
  input wire ftac_pkg::ftac_space_e flash_space_out,
  input wire logic flash_erase_out,
  input wire logic flash_program_out,
  input wire logic [15:0] flash_block_out,
  input wire logic [HOLD_DEPTH*8-1:0] flash_data_out
);
  import ftac_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic [31:0] stall_cnt_q;
  logic [1:0] key_q;
  logic key1;
  logic key2;
  logic rst_ev;
  // Key decode; the port is not a register, so keys live only here
  assign key1 = sfr_wr_in && sfr_idx_in == FTAC_IDX_UNLOCK_PORT
    && sfr_wdata_in == FTAC_KEY_FIRST;
  assign key2 = sfr_wr_in && sfr_idx_in == FTAC_IDX_UNLOCK_PORT
    && sfr_wdata_in == FTAC_KEY_SECOND;
  assign rst_ev = mclr_event_in || wdt_event_in;
  // Stall length, zero while idle
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stall_cnt_q <= '0;
    end else begin
      stall_cnt_q <= cpu_stall_out ? stall_cnt_q + 32'h1 : '0;
    end
  end
  // Unlock progress; any other access starts over
  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      key_q <= 2'h0;
    end else if (rst_ev) begin
      key_q <= 2'h0;
    end else if (sfr_wr_in || sfr_rd_in) begin
      key_q <= key1 ? 2'h1 : (key_q == 2'h1 && key2) ? 2'h2 : 2'h0;
    end
  end
  a_stall_means_op: assert property (
    cpu_stall_out == (flash_erase_out || flash_program_out))
    else $error("stall and array operation disagree");
  a_start_after_keys: assert property (
    $rose(cpu_stall_out) |-> $past(key_q) == 2'h2)
    else $error("cycle began without both keys");
  a_start_needs_en: assert property (
    $rose(cpu_stall_out) |-> $past(sfr_wr_in && sfr_idx_in == 3'h0
      && sfr_wdata_in[FTAC_BIT_PROG_EN] && sfr_wdata_in[FTAC_BIT_START]))
    else $error("cycle began without enabled start write");
  a_erase_select: assert property (
    $rose(cpu_stall_out) |->
      flash_erase_out == $past(sfr_wdata_in[FTAC_BIT_ERASE_SEL]))
    else $error("wrong operation kind");
  a_block_holds: assert property (
    cpu_stall_out && $past(cpu_stall_out) |-> $stable(flash_block_out))
    else $error("block address moved during cycle");
  a_cycle_length: assert property (
    $fell(cpu_stall_out) && !$past(rst_ev) |-> stall_cnt_q == PROG_CYCLES)
    else $error("cycle length wrong");
  a_cycle_bound: assert property (
    stall_cnt_q <= PROG_CYCLES)
    else $error("cycle overran its timer");
  a_table_done: assert property (
    tbl_done_out == $past(tbl_req_in && !cpu_stall_out))
    else $error("done pulse wrong");
  a_read_issue: assert property (
    flash_rd_out == $past(tbl_req_in && !tbl_is_write_in && !cpu_stall_out))
    else $error("array read wrong");
  a_config_read: assert property (
    flash_rd_out && flash_rd_addr_out[21] |->
      flash_space_out == FTAC_SPACE_CONFIG)
    else $error("top pointer bit not config space");
  a_unlock_reads_zero: assert property (
    sfr_idx_in == FTAC_IDX_UNLOCK_PORT |-> sfr_rdata_out == 8'h00)
    else $error("unlock port read not zero");
  a_event_stops: assert property (
    cpu_stall_out && rst_ev |=> !cpu_stall_out)
    else $error("reset event did not end cycle");
  a_refill_ones: assert property (
    $fell(flash_program_out) && !$past(rst_ev) |->
      ##[0:1] flash_data_out == {HOLD_DEPTH*8{1'b1}})
    else $error("holding block not refilled");
  c_erase: cover property ($rose(flash_erase_out));
  c_program: cover property ($rose(flash_program_out));
  c_read: cover property (flash_rd_out);
  c_abort: cover property (cpu_stall_out && rst_ev);
endmodule
bind ftac_ctrl ftac_ctrl_sva #(.PROG_CYCLES(PROG_CYCLES),
  .HOLD_DEPTH(HOLD_DEPTH)) i_sva (.clock_in, .reset_n_in, .mclr_event_in,
  .wdt_event_in, .sfr_idx_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in,
  .sfr_rdata_out, .tbl_req_in, .tbl_is_write_in, .tbl_done_out,
  .cpu_stall_out, .flash_rd_out, .flash_rd_addr_out, .flash_space_out,
  .flash_erase_out, .flash_program_out, .flash_block_out, .flash_data_out);

// ### tb/tb_flash_table_access_ctrl.sv
// Bench for the flash table access controller with a flash stand-in.
// Assumes a shortened cycle timer; the checker is bound separately.
`timescale 1ns/100ps
module tb_flash_table_access_ctrl;
  import ftac_pkg::*;
  localparam int CYC = 20;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic mclr_event_in = 1'b0;
  logic wdt_event_in = 1'b0;
  logic [2:0] sfr_idx_in = 3'h0;
  logic sfr_wr_in = 1'b0;
  logic sfr_rd_in = 1'b0;
  logic [7:0] sfr_wdata_in = 8'h00;
  logic [7:0] sfr_rdata_out;
  logic tbl_req_in = 1'b0;
  logic tbl_is_write_in = 1'b0;
  ftac_ptr_mode_e tbl_mode_in = FTAC_PTR_KEEP;
  logic tbl_done_out, cpu_stall_out, flash_rd_out;
  logic [21:0] flash_rd_addr_out;
  ftac_space_e flash_space_out, flash_op_space_out;
  logic [15:0] flash_word_in, flash_block_out;
  logic flash_erase_out, flash_program_out;
  logic [511:0] flash_data_out;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  ftac_ctrl #(.PROG_CYCLES(CYC), .HOLD_DEPTH(64)) i_dut (.clock_in,
    .reset_n_in, .mclr_event_in, .wdt_event_in, .sfr_idx_in, .sfr_wr_in,
    .sfr_rd_in, .sfr_wdata_in, .sfr_rdata_out, .tbl_req_in,
    .tbl_is_write_in, .tbl_mode_in, .tbl_done_out, .cpu_stall_out,
    .flash_rd_out, .flash_rd_addr_out, .flash_space_out, .flash_word_in,
    .flash_erase_out, .flash_program_out, .flash_block_out,
    .flash_op_space_out, .flash_data_out);
  ftac_flash_model i_flash (.rd_in(flash_rd_out),
    .addr_in(flash_rd_addr_out), .word_out(flash_word_in));
  // Clock and hang guard
  always #4 clock_in = ~clock_in;
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Register access, one idle cycle between strobes
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    @(posedge clock_in);
    sfr_wr_in <= 1'b1;
    sfr_idx_in <= idx;
    sfr_wdata_in <= d;
    @(posedge clock_in);
    sfr_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] idx, output logic [7:0] d);
    @(posedge clock_in);
    sfr_rd_in <= 1'b1;
    sfr_idx_in <= idx;
    @(negedge clock_in);
    d = sfr_rdata_out;
    @(posedge clock_in);
    sfr_rd_in <= 1'b0;
  endtask
  task automatic rdchk(input logic [2:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    rd(idx, d);
    chk(32'(d), 32'(exp));
  endtask
  task automatic set_ptr(input logic [21:0] p);
    wr(FTAC_IDX_PTR_UPPER, {2'b00, p[21:16]});
    wr(FTAC_IDX_PTR_HIGH, p[15:8]);
    wr(FTAC_IDX_PTR_LOW, p[7:0]);
  endtask
  task automatic chk_ptr(input logic [21:0] p);
    rdchk(FTAC_IDX_PTR_UPPER, {2'b00, p[21:16]});
    rdchk(FTAC_IDX_PTR_HIGH, p[15:8]);
    rdchk(FTAC_IDX_PTR_LOW, p[7:0]);
  endtask
  // Table op; returns in the cycle after it is taken
  task automatic tbl(input logic w, input ftac_ptr_mode_e m);
    @(posedge clock_in);
    tbl_req_in <= 1'b1;
    tbl_is_write_in <= w;
    tbl_mode_in <= m;
    @(posedge clock_in);
    tbl_req_in <= 1'b0;
    @(negedge clock_in);
  endtask
  function automatic logic [7:0] lat(input logic [21:0] p);
    return p[0] ? p[8:1] ^ 8'ha5 : p[8:1];
  endfunction
  // Enables first without start, keys, optional cancel, then start
  task automatic keys(input logic [7:0] a, input logic [7:0] b,
      input logic cancel, input logic [7:0] ctl);
    logic [7:0] d;
    wr(FTAC_IDX_NVM_CONTROL, ctl & 8'hfd);
    wr(FTAC_IDX_UNLOCK_PORT, a);
    if (cancel) begin
      rd(FTAC_IDX_BYTE_LATCH, d);
    end
    wr(FTAC_IDX_UNLOCK_PORT, b);
    wr(FTAC_IDX_NVM_CONTROL, ctl);
    @(negedge clock_in);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (cpu_stall_out === 1'b1 && n < 4 * CYC) begin
      @(negedge clock_in);
      n++;
    end
    chk(32'(cpu_stall_out), 32'h0);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 6; i++) begin
      rdchk(3'(i), 8'h00);
    end
    chk(32'(flash_data_out === '1), 32'h1);
    $display("test reset done");
  endtask
  task automatic t_modes();
    logic [21:0] ea [4] = '{22'h100, 22'h100, 22'h100, 22'h101};
    logic [21:0] ep [4] = '{22'h100, 22'h101, 22'h0ff, 22'h101};
    wr(FTAC_IDX_NVM_CONTROL, 8'h80);
    for (int m = 0; m < 4; m++) begin
      set_ptr(22'h000100);
      tbl(1'b0, ftac_ptr_mode_e'(m));
      chk(32'(flash_rd_addr_out), 32'(ea[m]));
      chk(32'(flash_space_out), 32'(FTAC_SPACE_PROGRAM));
      chk_ptr(ep[m]);
      rdchk(FTAC_IDX_BYTE_LATCH, lat(ea[m]));
    end
    wr(FTAC_IDX_PTR_UPPER, 8'hff);
    rdchk(FTAC_IDX_PTR_UPPER, 8'h3f);
    set_ptr(22'h3fffff);
    tbl(1'b0, FTAC_PTR_POST_INC);
    chk(32'(flash_rd_addr_out), 32'h3fffff);
    chk_ptr(22'h200000);
    rdchk(FTAC_IDX_BYTE_LATCH, lat(22'h3fffff));
    tbl(1'b0, FTAC_PTR_POST_DEC);
    chk_ptr(22'h3fffff);
    $display("test pointer modes done");
  endtask
  task automatic t_hold();
    set_ptr(22'h1234c5);
    wr(FTAC_IDX_BYTE_LATCH, 8'h3c);
    tbl(1'b1, FTAC_PTR_KEEP);
    chk(32'(tbl_done_out), 32'h1);
    chk(32'(flash_data_out[47:40]), 32'h3c);
    set_ptr(22'h000045);
    wr(FTAC_IDX_BYTE_LATCH, 8'h77);
    tbl(1'b1, FTAC_PTR_POST_INC);
    chk(32'(flash_data_out[47:40]), 32'h77);
    chk(32'(flash_data_out[55:48]), 32'hff);
    chk_ptr(22'h000046);
    $display("test holding block done");
  endtask
  task automatic t_cycle(input logic erase, input logic [21:0] p);
    logic [7:0] d;
    set_ptr(p);
    keys(FTAC_KEY_FIRST, FTAC_KEY_SECOND, 1'b0, erase ? 8'h96 : 8'h86);
    chk(32'(cpu_stall_out), 32'h1);
    chk(32'({flash_erase_out, flash_program_out}), {erase, ~erase});
    chk(32'(flash_block_out), 32'(p[21:6]));
    chk(32'(flash_op_space_out), 32'(FTAC_SPACE_PROGRAM));
    wr(FTAC_IDX_NVM_CONTROL, 8'h84);
    rdchk(FTAC_IDX_NVM_CONTROL, erase ? 8'h9e : 8'h8e);
    tbl(1'b0, FTAC_PTR_KEEP);
    chk(32'({flash_rd_out, tbl_done_out}), 32'h0);
    wait_idle();
    rd(FTAC_IDX_NVM_CONTROL, d);
    chk(32'({d[3], d[1]}), 32'h0);
    chk(32'(flash_data_out === '1), 32'h1);
    $display("test cycle done");
  endtask
  task automatic t_refuse();
    keys(FTAC_KEY_FIRST, FTAC_KEY_SECOND, 1'b0, 8'h82);
    chk(32'(cpu_stall_out), 32'h0);
    keys(FTAC_KEY_FIRST, FTAC_KEY_SECOND, 1'b1, 8'h86);
    chk(32'(cpu_stall_out), 32'h0);
    keys(FTAC_KEY_FIRST, 8'hab, 1'b0, 8'h86);
    chk(32'(cpu_stall_out), 32'h0);
    keys(FTAC_KEY_SECOND, FTAC_KEY_FIRST, 1'b0, 8'h86);
    chk(32'(cpu_stall_out), 32'h0);
    $display("test refusals done");
  endtask
  task automatic t_abort();
    for (int e = 0; e < 2; e++) begin
      keys(FTAC_KEY_FIRST, FTAC_KEY_SECOND, 1'b0, 8'hc6);
      chk(32'(flash_op_space_out), 32'(FTAC_SPACE_CONFIG));
      @(posedge clock_in);
      mclr_event_in <= (e == 0);
      wdt_event_in <= (e == 1);
      @(posedge clock_in);
      mclr_event_in <= 1'b0;
      wdt_event_in <= 1'b0;
      @(negedge clock_in);
      chk(32'(cpu_stall_out), 32'h0);
      rdchk(FTAC_IDX_NVM_CONTROL, 8'hc8);
    end
    $display("test abort done");
  endtask
  // Main sequence, with a second reset in mid-run
  initial begin
    repeat (20) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset();
    t_modes();
    t_hold();
    t_cycle(1'b0, 22'h1234c5);
    t_cycle(1'b1, 22'h0abcd7);
    t_refuse();
    t_abort();
    @(posedge clock_in);
    reset_n_in <= 1'b0;
    repeat (3) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset();
    report_and_stop();
  end
endmodule
